// >>> hw/vpic_ctrl.v
`timescale 1ns/100ps
`include "vpic_defs.vh"
// Function
// RULE1 - many peripheral request lines merge into one core request
// RULE2 - up to eight trap and exception sources beside peripheral sources
// RULE3 - each source carries one of eight user priority levels
// RULE4 - equal levels resolve by fixed order, not programmable
// RULE5 - every source gets its own vector table entry
// RULE6 - entry and return latencies are fixed cycle counts
// RULE7 - vector table sits in program memory starting at 000004h
// RULE8 - seven trap vectors cannot be masked by priority; the code masks them while cpuLevel is 8 or more
// RULE9 - table holds up to 246 interrupt sources after traps
// RULE10 - each entry is a 24-bit address delivered whole to core
// RULE11 - software fills each used entry with its handler address
// RULE12 - lower vector position has higher natural priority
// RULE13 - reset bypasses controller and starts execution at address zero
// RULE14 - request only for best source above current core priority
// RULE15 - reset clears arbitration state, request low until pending source
module vpic_ctrl #(
	parameter NUM_IRQS = `VPIC_NUM_IRQS,
	parameter NUM_TRAPS = `VPIC_NUM_TRAPS
) (
	// clock and reset
	input wire clk,
	input wire nrst,
	// peripheral and trap requests, levels packed three bits per peripheral source
	input wire [NUM_TRAPS-1:0] trapReq,
	input wire [NUM_IRQS-1:0] irqReq,
	input wire [3*NUM_IRQS-1:0] irqLevel,
	// core side
	input wire [3:0] cpuLevel,
	input wire intAck,
	input wire retStart,
	// program memory read port for the vector table
	output reg vecRead,
	output reg [`VPIC_ADDR_W-1:0] vecAddr,
	input wire [`VPIC_ADDR_W-1:0] vecData,
	// answer to core
	output reg intReq,
	output reg [`VPIC_ID_W-1:0] intId,
	output reg [3:0] intLevel,
	output reg handlerValid,
	output reg [`VPIC_ADDR_W-1:0] handlerAddr,
	output reg resumeValid,
	output reg [`VPIC_ADDR_W-1:0] resetAddr
);
	localparam N = NUM_TRAPS + NUM_IRQS;
	localparam ST_IDLE = `VPIC_ST_IDLE;
	localparam ST_FETCH = `VPIC_ST_FETCH;
	localparam ST_ENTRY = `VPIC_ST_ENTRY;
	localparam ST_RETURN = `VPIC_ST_RETURN;

	// flattened source list: traps first, then peripherals, in vector order
	wire [N-1:0] srcValid;
	wire [4*N-1:0] srcLevel;
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : gSrc
			if (g < NUM_TRAPS) begin : gTrap
				assign srcValid[g] = trapReq[g]; // RULE2 RULE8
				assign srcLevel[4*g+3:4*g] = `VPIC_TRAP_LEVEL; // RULE8
			end else begin : gIrq
				assign srcValid[g] = irqReq[g-NUM_TRAPS]; // RULE1 RULE9
				assign srcLevel[4*g+3:4*g] = {1'b0,
					irqLevel[3*(g-NUM_TRAPS)+2:3*(g-NUM_TRAPS)]}; // RULE3
			end
		end
	endgenerate

	// linear chain of nodes; later index wins on strictly higher level, or when no earlier source is valid
	wire [N-1:0] chValid;
	wire [4*N-1:0] chLevel;
	wire [`VPIC_ID_W*N-1:0] chId;
	assign chValid[0] = srcValid[0];
	assign chLevel[3:0] = srcLevel[3:0];
	assign chId[`VPIC_ID_W-1:0] = {`VPIC_ID_W{1'b0}};
	generate
		for (g = 1; g < N; g = g + 1) begin : gArb
			// vector index of this node's new entrant, held at the id width
			localparam [`VPIC_ID_W-1:0] SRC_ID = g;
			vpic_cmp #(.ID_W(`VPIC_ID_W)) uCmp (
				.aValid(chValid[g-1]),
				.aLevel(chLevel[4*g-1:4*g-4]),
				.aId(chId[`VPIC_ID_W*g-1:`VPIC_ID_W*(g-1)]),
				.bValid(srcValid[g]),
				.bLevel(srcLevel[4*g+3:4*g]),
				.bId(SRC_ID),
				.oValid(chValid[g]),
				.oLevel(chLevel[4*g+3:4*g]),
				.oId(chId[`VPIC_ID_W*(g+1)-1:`VPIC_ID_W*g])
			); // RULE4 RULE12
		end
	endgenerate

	wire bestValid;
	wire [3:0] bestLevel;
	wire [`VPIC_ID_W-1:0] bestId;
	wire eligible;
	assign bestValid = chValid[N-1];
	assign bestLevel = chLevel[4*N-1:4*N-4];
	assign bestId = chId[`VPIC_ID_W*N-1:`VPIC_ID_W*(N-1)];
	// level zero never interrupts; traps exceed the core level only while cpuLevel is below 8
	assign eligible = bestValid && (bestLevel != 4'h0) && (bestLevel > cpuLevel); // RULE14 RULE8

	// vector slot address: base plus two words per entry
	wire [`VPIC_ADDR_W-1:0] slotAddr;
	assign slotAddr = `VPIC_TABLE_BASE +
		{{(`VPIC_ADDR_W-`VPIC_ID_W-1){1'b0}}, intId, 1'b0}; // RULE5 RULE7

	reg [3:0] state;
	reg [3:0] next_state;
	reg [3:0] count;
	reg [3:0] next_count;

	// sequencer next state
	always @* begin
		next_state = state;
		next_count = count;
		case (state)
			ST_IDLE: begin
				if (intReq && intAck) begin
					next_state = ST_FETCH;
					next_count = 4'h1;
				end else if (retStart) begin
					next_state = ST_RETURN;
					next_count = 4'h1;
				end
			end
			ST_FETCH: begin
				next_state = ST_ENTRY;
				next_count = count + 4'h1;
			end
			ST_ENTRY: begin
				if (count >= `VPIC_ENTRY_CYCLES) begin // RULE6
					next_state = ST_IDLE;
					next_count = 4'h0;
				end else begin
					next_count = count + 4'h1;
				end
			end
			ST_RETURN: begin
				if (count >= `VPIC_RETURN_CYCLES) begin // RULE6
					next_state = ST_IDLE;
					next_count = 4'h0;
				end else begin
					next_count = count + 4'h1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_count = 4'h0;
			end
		endcase
	end

	// sequencer state and latency counter
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE; // RULE15
			count <= 4'h0;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// reset start address; a reset never goes through the vector table
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resetAddr <= `VPIC_RESET_ADDR; // RULE13
		end else begin
			resetAddr <= `VPIC_RESET_ADDR; // RULE13
		end
	end

	// arbitration result tracked only while the sequencer stays idle; a taken
	// acknowledge or return freezes the winner and drops the request, so the
	// core never sees a request that the sequencer could not accept
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intReq <= 1'b0; // RULE15
			intId <= {`VPIC_ID_W{1'b0}};
			intLevel <= 4'h0;
		end else if (state == ST_IDLE && next_state == ST_IDLE) begin
			intReq <= eligible; // RULE1 RULE14
			intId <= bestId;
			intLevel <= bestLevel;
		end else begin
			intReq <= 1'b0;
		end
	end

	// program memory read of the winner's slot, two cycles after the acknowledge
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			vecRead <= 1'b0;
			vecAddr <= {`VPIC_ADDR_W{1'b0}};
		end else begin
			vecRead <= (state == ST_FETCH);
			if (state == ST_FETCH) begin
				vecAddr <= slotAddr; // RULE5 RULE7
			end
		end
	end

	// answer pulses at the end of the fixed entry and return counts; the
	// table word is taken late so memory has a full cycle after the read
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			handlerValid <= 1'b0;
			handlerAddr <= {`VPIC_ADDR_W{1'b0}};
			resumeValid <= 1'b0;
		end else begin
			handlerValid <= 1'b0;
			resumeValid <= 1'b0;
			if (state == ST_ENTRY && count >= `VPIC_ENTRY_CYCLES) begin
				handlerValid <= 1'b1; // RULE6
				handlerAddr <= vecData; // RULE10 RULE11
			end
			if (state == ST_RETURN && count >= `VPIC_RETURN_CYCLES) begin
				resumeValid <= 1'b1; // RULE6
			end
		end
	end
endmodule // vpic_ctrl

// >>> hw/vpic_defs.vh
`ifndef VPIC_DEFS_VH
`define VPIC_DEFS_VH
// vector table placement and layout
`define VPIC_TABLE_BASE 24'h00_0004
`define VPIC_ADDR_W 24
`define VPIC_RESET_ADDR 24'h00_0000
// source counts
`define VPIC_NUM_TRAPS 7
`define VPIC_MAX_TRAPS 8
`define VPIC_NUM_IRQS 246
`define VPIC_LEVEL_W 3
`define VPIC_ID_W 8
// fixed latencies in cycles
`define VPIC_ENTRY_CYCLES 4'h3
`define VPIC_RETURN_CYCLES 4'h3
// level given to traps, above every user level
`define VPIC_TRAP_LEVEL 4'h8
// state codes, one-hot
`define VPIC_ST_IDLE 4'h1
`define VPIC_ST_FETCH 4'h2
`define VPIC_ST_ENTRY 4'h4
`define VPIC_ST_RETURN 4'h8
`endif

// >>> hw/vpic_cmp.v
`timescale 1ns/100ps
// one arbitration node: higher level wins, equal level keeps the lower index
module vpic_cmp #(
	parameter ID_W = 8
) (
	// side a, lower natural index
	input wire aValid,
	input wire [3:0] aLevel,
	input wire [ID_W-1:0] aId,
	// side b, higher natural index
	input wire bValid,
	input wire [3:0] bLevel,
	input wire [ID_W-1:0] bId,
	// winner
	output wire oValid,
	output wire [3:0] oLevel,
	output wire [ID_W-1:0] oId
);
	wire pickB;
	// b wins with a strictly higher level, or whenever a is not valid
	assign pickB = bValid && (!aValid || (bLevel > aLevel)); // RULE4 RULE12
	assign oValid = aValid | bValid;
	assign oLevel = pickB ? bLevel : aLevel;
	assign oId = pickB ? bId : aId;
endmodule // vpic_cmp

// >>> verification/vpic_ctrl_sva.sv
`timescale 1ns/100ps
module vpic_ctrl_sva #(parameter NUM_IRQS = 246, parameter NUM_TRAPS = 7) (
	// clock, reset and requests
	input clk, nrst, intAck, retStart,
	input [NUM_TRAPS-1:0] trapReq,
	input [NUM_IRQS-1:0] irqReq,
	input [3:0] cpuLevel,
	// answers
	input vecRead, intReq, handlerValid, resumeValid,
	input [23:0] vecAddr, vecData, handlerAddr,
	input [7:0] intId,
	input [3:0] intLevel
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_ent; intReq && intAck |=> !intReq ##1 vecRead ##1 !handlerValid ##1 handlerValid;
	endproperty
	a_ent: assert property (p_ent) else $error("entry timing");
	property p_slot; vecRead |-> vecAddr == 24'h00_0004 + {15'h0000, intId, 1'b0}; endproperty
	a_slot: assert property (p_slot) else $error("slot address");
	property p_data; handlerValid |-> handlerAddr == $past(vecData); endproperty
	a_data: assert property (p_data) else $error("handler address");
	property p_ret; resumeValid |-> $past(retStart, 4); endproperty
	a_ret: assert property (p_ret) else $error("return timing");
	property p_lvl; $rose(intReq) |-> intLevel > $past(cpuLevel); endproperty
	a_lvl: assert property (p_lvl) else $error("level not above core");
	property p_trap; $rose(intReq) && $past(trapReq[0]) |-> intId == 8'h00 && intLevel == 4'h8;
	endproperty
	a_trap: assert property (p_trap) else $error("trap lost");
	property p_src; intReq && intId >= 8'h07 |-> intLevel != 4'h0 && intLevel < 4'h8; endproperty
	a_src: assert property (p_src) else $error("peripheral level");
	property p_why; $rose(intReq) |-> $past(trapReq) != 0 || $past(irqReq) != 0; endproperty
	a_why: assert property (p_why) else $error("request without source");
endmodule // vpic_ctrl_sva
bind vpic_ctrl vpic_ctrl_sva #(.NUM_IRQS(NUM_IRQS), .NUM_TRAPS(NUM_TRAPS)) i_sva (
	.clk(clk), .nrst(nrst), .intAck(intAck), .retStart(retStart), .trapReq(trapReq),
	.irqReq(irqReq), .cpuLevel(cpuLevel), .vecRead(vecRead), .intReq(intReq),
	.handlerValid(handlerValid), .resumeValid(resumeValid), .vecAddr(vecAddr),
	.vecData(vecData), .handlerAddr(handlerAddr), .intId(intId), .intLevel(intLevel));

// >>> verification/vpic_core_model.sv
`timescale 1ns/100ps
module vpic_core_model (
	// clock, reset and controller outputs
	input clk, nrst, intReq, vecRead, handlerValid,
	input [23:0] vecAddr,
	// wait before accepting, answers
	input [3:0] ackDelay,
	output reg intAck,
	output reg [23:0] vecData
);
	reg [3:0] ackWait;
	// one ack pulse after the wait; table word held until the handler is taken
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			intAck <= 1'h0;
			ackWait <= 4'h0;
			vecData <= 24'h00_0000;
		end else begin
			ackWait <= (intReq && !intAck) ? ackWait + 4'h1 : 4'h0;
			intAck <= intReq && !intAck && ackWait >= ackDelay;
			if (vecRead)
				vecData <= vecAddr ^ 24'h5A_5A5A;
			else if (handlerValid)
				vecData <= ~vecData;
		end
	end
endmodule // vpic_core_model

// >>> verification/vpic_ctrl_test.sv
`timescale 1ns/100ps
module vpic_ctrl_test;
	// stimulus, wires and counters
	reg clk = 1'h0, nrst = 1'h0, retStart = 1'h0;
	reg [6:0] trapReq = 7'h00;
	reg [245:0] irqReq = 246'h0;
	reg [737:0] irqLevel = 738'h0;
	reg [3:0] cpuLevel = 4'h0, ackDelay = 4'h0;
	integer nMismatch = 0, checksDone = 0, k;
	wire intAck, vecRead, intReq, handlerValid, resumeValid;
	wire [23:0] vecAddr, vecData, handlerAddr, resetAddr;
	wire [7:0] intId;
	wire [3:0] intLevel;
	// 40 MHz clock
	initial forever #12.5 clk = ~clk;
	vpic_ctrl i_dut (.clk(clk), .nrst(nrst), .trapReq(trapReq), .irqReq(irqReq),
		.irqLevel(irqLevel), .cpuLevel(cpuLevel), .intAck(intAck), .retStart(retStart),
		.vecRead(vecRead), .vecAddr(vecAddr), .vecData(vecData), .intReq(intReq),
		.intId(intId), .intLevel(intLevel), .handlerValid(handlerValid),
		.handlerAddr(handlerAddr), .resumeValid(resumeValid), .resetAddr(resetAddr));
	vpic_core_model i_core (.clk(clk), .nrst(nrst), .intReq(intReq), .vecRead(vecRead),
		.handlerValid(handlerValid), .vecAddr(vecAddr), .ackDelay(ackDelay),
		.intAck(intAck), .vecData(vecData));
	task testDone;
		begin
			$display("checks %0d mismatches %0d", checksDone, nMismatch);
			if (nMismatch == 0 && checksDone > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task check(input string what, input [23:0] exp, input [23:0] got);
		begin
			checksDone = checksDone + 1;
			if (got !== exp) begin
				nMismatch = nMismatch + 1;
				$display("ERROR %0s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// wait for the handler pulse, then judge winner and fetched address
	task serve(input [7:0] id, input [3:0] lvl);
		begin
			k = 0;
			@(negedge clk);
			while (handlerValid !== 1'b1 && k < 40) begin
				@(negedge clk);
				k = k + 1;
			end
			if (k == 40) begin
				nMismatch = nMismatch + 1;
				testDone;
			end
			check("id", id, intId);
			check("level", lvl, intLevel);
			check("handler", (24'h00_0004 + 2 * id) ^ 24'h5A_5A5A, handlerAddr);
		end
	endtask
	task tieOrder;
		begin
			irqLevel[9 +: 3] = 3'h5;
			irqLevel[600 +: 3] = 3'h5;
			irqReq[3] = 1'h1;
			irqReq[200] = 1'h1;
			serve(8'h0A, 4'h5);
			irqReq[3] = 1'h0;
			serve(8'hCF, 4'h5);
			irqReq[200] = 1'h0;
		end
	endtask
	task levelWins;
		begin
			irqLevel[9 +: 3] = 3'h2;
			irqLevel[600 +: 3] = 3'h6;
			irqReq[3] = 1'h1;
			irqReq[200] = 1'h1;
			serve(8'hCF, 4'h6);
			irqReq[200] = 1'h0;
			serve(8'h0A, 4'h2);
			irqReq[3] = 1'h0;
		end
	endtask
	task maskTrap;
		begin
			cpuLevel = 4'h5;
			irqLevel[9 +: 3] = 3'h5;
			irqReq[3] = 1'h1;
			repeat (10) @(negedge clk);
			check("masked", 24'h00_0000, intReq);
			trapReq[6] = 1'h1;
			cpuLevel = 4'h7;
			serve(8'h06, 4'h8);
			trapReq[6] = 1'h0;
			cpuLevel = 4'h4;
			serve(8'h0A, 4'h5);
			irqReq[3] = 1'h0;
			cpuLevel = 4'h0;
		end
	endtask
	// slow core, first trap against the last peripheral
	task slowTrap;
		begin
			ackDelay = 4'h5;
			irqLevel[735 +: 3] = 3'h7;
			irqReq[245] = 1'h1;
			trapReq[0] = 1'h1;
			serve(8'h00, 4'h8);
			trapReq[0] = 1'h0;
			serve(8'hFC, 4'h7);
			irqReq[245] = 1'h0;
			ackDelay = 4'h0;
		end
	endtask
	task returnPath;
		begin
			@(negedge clk);
			retStart = 1'h1;
			@(negedge clk);
			retStart = 1'h0;
			repeat (2) begin
				@(negedge clk);
				check("early resume", 24'h00_0000, resumeValid);
			end
			@(negedge clk);
			check("resume", 24'h00_0001, resumeValid);
			@(negedge clk);
			check("resume pulse", 24'h00_0000, resumeValid);
		end
	endtask
	// reset in mid-run drops a pending request, which returns once released
	task resetMid;
		begin
			irqLevel[9 +: 3] = 3'h3;
			irqReq[3] = 1'h1;
			@(negedge clk);
			check("pending request", 24'h00_0001, intReq);
			nrst = 1'h0;
			@(negedge clk);
			check("reset request", 24'h00_0000, intReq);
			check("reset handler", 24'h00_0000, handlerAddr);
			nrst = 1'h1;
			serve(8'h0A, 4'h3);
			irqReq[3] = 1'h0;
		end
	endtask
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1'h1;
		repeat (2) @(negedge clk);
		check("idle request", 24'h00_0000, intReq);
		check("reset address", 24'h00_0000, resetAddr);
		tieOrder;
		levelWins;
		maskTrap;
		slowTrap;
		returnPath;
		resetMid;
		testDone;
	end
endmodule // vpic_ctrl_test
